//--- hw/ccm_pkg.sv
// Purpose: constants and types shared by the converter control block
// Assumes: byte-wide register port behind the serial interface
// Notes: two-byte coefficients keep the high byte at the lower address
//
// Summary of operation
// - Mode field decodes idle, run, single, down, cals
// - Positive DAC connect bit links DAC to input
// - Positive DAC code is low seven bits
// - Negative DAC connect bit links DAC to input
// - Negative DAC code is low seven bits
// - Offset coefficient 0x0D/0x0E, high first, reset 0x8000
// - Offset calibration writes new coefficient automatically
// - Offset coefficient subtracted from capacitive results
// - Capacitive gain at 0x0F/0x10, shared, factory
// - Voltage gain at 0x11/0x12 scales voltage results
// - Capacitive filter output corrected by offset and gain, voltage output by gain
// - Single-ended mode disconnects negative input pin
// - Differential result is difference after DAC offsets
// - Two excitation outputs programmed independently
// - Mode in low bits of 0x0A, reset 0xA0
// - Factory gain copied into gain register at reset
// - Offset coefficient returns to default at reset
// - Offset calibration maps zero input to midpoint
////////////////////////////////////////////////////////////////////////
package ccm_pkg;
	localparam int CCM_DATA_W = 24;
	localparam int CCM_COEF_W = 16;
	localparam int OFF_LSB_SHIFT = 6;
	localparam int GAIN_ONE_SHIFT = 15;

	localparam logic [7:0] ADR_CAP_SETUP = 8'h07;
	localparam logic [7:0] ADR_EXC_SETUP = 8'h09;
	localparam logic [7:0] ADR_CFG = 8'h0A;
	localparam logic [7:0] ADR_DAC_POS = 8'h0B;
	localparam logic [7:0] ADR_DAC_NEG = 8'h0C;
	localparam logic [7:0] ADR_OFF_HI = 8'h0D;
	localparam logic [7:0] ADR_OFF_LO = 8'h0E;
	localparam logic [7:0] ADR_CGAIN_HI = 8'h0F;
	localparam logic [7:0] ADR_CGAIN_LO = 8'h10;
	localparam logic [7:0] ADR_VGAIN_HI = 8'h11;
	localparam logic [7:0] ADR_VGAIN_LO = 8'h12;

	localparam logic [7:0] RST_CAP_SETUP = 8'h00;
	localparam logic [7:0] RST_EXC_SETUP = 8'h03;
	localparam logic [7:0] RST_CFG = 8'hA0;
	localparam logic [7:0] RST_DAC = 8'h00;
	localparam logic [15:0] RST_OFF_COEF = 16'h8000;
	localparam logic [15:0] RST_GAIN_COEF = 16'h0000;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	localparam int BIT_DAC_CONN = 7;
	localparam int BIT_DIFF = 5;
	localparam int BIT_EXC2_EN = 5;
	localparam int BIT_EXC2_INV = 4;
	localparam int BIT_EXC1_EN = 3;
	localparam int BIT_EXC1_INV = 2;

	typedef enum logic [2:0] {
		MODE_IDLE = 3'h0,
		MODE_CONT = 3'h1,
		MODE_SINGLE = 3'h2,
		MODE_PWRDN = 3'h3,
		MODE_OFFCAL = 3'h5,
		MODE_GAINCAL = 3'h6
	} ccm_mode_t;
endpackage

//--- hw/ccm_corrector.sv
// Purpose: digital offset and gain correction of filter results
// Assumes: offset is a signed step around the coefficient midpoint
// Notes: one cycle of latency; calibration values are combinational
////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module ccm_corrector
	import ccm_pkg::*;
#(
	parameter int DATA_W = CCM_DATA_W,
	parameter int COEF_W = CCM_COEF_W
) (
	// Clock and synchronised reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Raw filter result
	input wire logic [DATA_W-1:0] raw_i,
	input wire logic valid_i,
	input wire logic is_cap_i,
	// Coefficients in use
	input wire logic [COEF_W-1:0] off_coef_i,
	input wire logic [COEF_W-1:0] gain_i,
	// Corrected result
	output logic [DATA_W-1:0] res_o,
	output logic res_valid_o,
	output logic res_is_cap_o,
	// Coefficients derived from the present input
	output logic [COEF_W-1:0] cal_off_o,
	output logic [COEF_W-1:0] cal_gain_o
);
	localparam int EW = DATA_W + 2;
	localparam int PW = EW + COEF_W + 1;
	localparam logic signed [PW-1:0] P_MID = PW'(1) <<< (DATA_W - 1);
	localparam logic signed [PW-1:0] P_HI = P_MID - PW'(1);
	localparam logic signed [PW-1:0] P_NUM = P_HI <<< GAIN_ONE_SHIFT;
	localparam logic signed [PW-1:0] G_MAX = (PW'(1) <<< COEF_W) - PW'(1);
	localparam logic signed [EW-1:0] C_MID = EW'(1) <<< (COEF_W - 1);

	// Offset steps must fit inside the result span
	if (COEF_W < 2 || COEF_W + OFF_LSB_SHIFT > DATA_W) begin : g_chk
		$error("ccm_corrector: unsupported widths");
	end

	typedef struct packed {
		logic [DATA_W-1:0] res;
		logic vld;
		logic is_cap;
	} ccm_corr_t;

	ccm_corr_t st_q;
	ccm_corr_t st_d;
	logic signed [EW-1:0] dlt;
	logic signed [EW-1:0] offs;
	logic signed [EW-1:0] err;
	logic signed [EW-1:0] coff;
	logic signed [PW-1:0] scl;
	logic signed [PW-1:0] gq;

	always_comb begin
		st_d = st_q;
		dlt = $signed({2'b00, raw_i}) - EW'(P_MID);
		// Offset step is 64 result codes
		offs = EW'($signed({1'b0, off_coef_i})) - C_MID;
		offs = offs <<< OFF_LSB_SHIFT;
		err = dlt - offs;
		scl = (PW'(err) * $signed({1'b0, gain_i})) >>> GAIN_ONE_SHIFT;
		st_d.vld = valid_i;
		if (valid_i) begin
			st_d.is_cap = is_cap_i;
			if (scl > P_HI) begin
				st_d.res = {DATA_W{1'b1}};
			end else if (scl < -P_MID) begin
				st_d.res = '0;
			end else begin
				st_d.res = DATA_W'(scl + P_MID);
			end
		end
		// Coefficient that puts this input on the midpoint code
		coff = (dlt >>> OFF_LSB_SHIFT) + C_MID;
		if (coff > (C_MID <<< 1) - EW'(1)) begin
			cal_off_o = {COEF_W{1'b1}};
		end else if (coff < 0) begin
			cal_off_o = '0;
		end else begin
			cal_off_o = COEF_W'(coff);
		end
		// Full-scale input should land on the top code
		gq = (err > 0) ? P_NUM / PW'(err) : G_MAX;
		cal_gain_o = (gq > G_MAX) ? COEF_W'(G_MAX) : COEF_W'(gq);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign res_o = st_q.res;
	assign res_valid_o = st_q.vld;
	assign res_is_cap_o = st_q.is_cap;
endmodule
`default_nettype wire

//--- hw/ccm_ctrl.sv
// Purpose: mode, offset DAC and calibration coefficient control
// Assumes: register port is the byte side of the serial interface
// Notes: DAC, mode and excitation outputs steer the analog core
////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module ccm_ctrl
	import ccm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Factory coefficients from one-time memory
	input wire logic [15:0] otp_cap_gain_i,
	input wire logic [15:0] otp_volt_gain_i,
	// Digital filter output
	input wire logic [23:0] filt_data_i,
	input wire logic filt_valid_i,
	input wire logic filt_is_cap_i,
	// Converter mode controls
	output logic conv_run_o,
	output logic pwr_down_o,
	output logic off_cal_o,
	output logic gain_cal_o,
	// Offset-cancelling DACs and input switches
	output logic pos_offset_dac_connect_o,
	output logic [6:0] pos_offset_dac_code_o,
	output logic neg_offset_dac_connect_o,
	output logic [6:0] neg_offset_dac_code_o,
	output logic cap_input_neg_connect_o,
	output logic differential_select_o,
	// Excitation outputs
	output logic excitation_out_first_en_o,
	output logic excitation_out_first_inv_o,
	output logic excitation_out_second_en_o,
	output logic excitation_out_second_inv_o,
	// Corrected result
	output logic [23:0] result_o,
	output logic result_valid_o,
	output logic result_is_cap_o
);
	typedef struct packed {
		logic [7:0] cap_setup;
		logic [7:0] exc_setup;
		logic [7:0] cfg;
		logic [7:0] dac_pos;
		logic [7:0] dac_neg;
		logic [15:0] off_coef;
		logic [15:0] cgain;
		logic [15:0] vgain;
		logic [7:0] rdata;
		logic otp_pend;
		logic conv_run;
		logic pwr_down;
		logic off_cal;
		logic gain_cal;
	} ccm_state_t;

	localparam ccm_state_t ST_RST = '{
		cap_setup: RST_CAP_SETUP,
		exc_setup: RST_EXC_SETUP,
		cfg: RST_CFG,
		dac_pos: RST_DAC,
		dac_neg: RST_DAC,
		off_coef: RST_OFF_COEF,
		cgain: RST_GAIN_COEF,
		vgain: RST_GAIN_COEF,
		rdata: RD_UNMAPPED,
		otp_pend: 1'b1,
		conv_run: 1'b0,
		pwr_down: 1'b0,
		off_cal: 1'b0,
		gain_cal: 1'b0
	};

	////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////
	// Correction datapath
	ccm_state_t st_q;
	ccm_state_t st_d;
	logic [15:0] use_off;
	logic [15:0] use_gain;
	logic [15:0] cal_off;
	logic [15:0] cal_gain;
	logic [2:0] cur_mode;
	logic [2:0] nxt_mode;

	// Voltage results see a zero offset step
	assign use_off = filt_is_cap_i ? st_q.off_coef : RST_OFF_COEF;
	// One capacitive gain serves both capacitive inputs
	assign use_gain = filt_is_cap_i ? st_q.cgain : st_q.vgain;
	assign cur_mode = st_q.cfg[2:0];

	ccm_corrector #(
		.DATA_W(CCM_DATA_W),
		.COEF_W(CCM_COEF_W)
	) u_corr (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.raw_i(filt_data_i),
		.valid_i(filt_valid_i),
		.is_cap_i(filt_is_cap_i),
		.off_coef_i(use_off),
		.gain_i(use_gain),
		.res_o(result_o),
		.res_valid_o(result_valid_o),
		.res_is_cap_o(result_is_cap_o),
		.cal_off_o(cal_off),
		.cal_gain_o(cal_gain)
	);

	////////////////////////////////////////////////////////////////////
	// Register file, calibration and mode sequencing
	always_comb begin
		st_d = st_q;
		st_d.otp_pend = 1'b0;
		if (st_q.otp_pend) begin
			st_d.cgain = otp_cap_gain_i;
			st_d.vgain = otp_volt_gain_i;
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADR_CAP_SETUP: begin
					st_d.cap_setup = reg_wdata_i;
				end
				ADR_EXC_SETUP: begin
					st_d.exc_setup = reg_wdata_i;
				end
				ADR_CFG: begin
					st_d.cfg = reg_wdata_i;
				end
				ADR_DAC_POS: begin
					st_d.dac_pos = reg_wdata_i;
				end
				ADR_DAC_NEG: begin
					st_d.dac_neg = reg_wdata_i;
				end
				ADR_OFF_HI: begin
					st_d.off_coef[15:8] = reg_wdata_i;
				end
				ADR_OFF_LO: begin
					st_d.off_coef[7:0] = reg_wdata_i;
				end
				ADR_CGAIN_HI: begin
					st_d.cgain[15:8] = reg_wdata_i;
				end
				ADR_CGAIN_LO: begin
					st_d.cgain[7:0] = reg_wdata_i;
				end
				ADR_VGAIN_HI: begin
					st_d.vgain[15:8] = reg_wdata_i;
				end
				ADR_VGAIN_LO: begin
					st_d.vgain[7:0] = reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
		// A finishing run beats a host write in the same cycle
		if (filt_valid_i) begin
			case (cur_mode)
				MODE_SINGLE: begin
					st_d.cfg[2:0] = MODE_IDLE;
				end
				MODE_OFFCAL: begin
					if (filt_is_cap_i) begin
						st_d.off_coef = cal_off;
						st_d.cfg[2:0] = MODE_IDLE;
					end
				end
				MODE_GAINCAL: begin
					if (filt_is_cap_i) begin
						st_d.cgain = cal_gain;
					end else begin
						st_d.vgain = cal_gain;
					end
					st_d.cfg[2:0] = MODE_IDLE;
				end
				default: begin
				end
			endcase
		end
		nxt_mode = st_d.cfg[2:0];
		// Unlisted codes leave the converter stopped
		st_d.conv_run = (nxt_mode == MODE_CONT) ||
			(nxt_mode == MODE_SINGLE);
		st_d.pwr_down = (nxt_mode == MODE_PWRDN);
		st_d.off_cal = (nxt_mode == MODE_OFFCAL);
		st_d.gain_cal = (nxt_mode == MODE_GAINCAL);
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADR_CAP_SETUP: st_d.rdata = st_q.cap_setup;
				ADR_EXC_SETUP: st_d.rdata = st_q.exc_setup;
				ADR_CFG: st_d.rdata = st_q.cfg;
				ADR_DAC_POS: st_d.rdata = st_q.dac_pos;
				ADR_DAC_NEG: st_d.rdata = st_q.dac_neg;
				ADR_OFF_HI: st_d.rdata = st_q.off_coef[15:8];
				ADR_OFF_LO: st_d.rdata = st_q.off_coef[7:0];
				ADR_CGAIN_HI: st_d.rdata = st_q.cgain[15:8];
				ADR_CGAIN_LO: st_d.rdata = st_q.cgain[7:0];
				ADR_VGAIN_HI: st_d.rdata = st_q.vgain[15:8];
				ADR_VGAIN_LO: st_d.rdata = st_q.vgain[7:0];
				default: st_d.rdata = RD_UNMAPPED;
			endcase
		end
	end

	// Reset drops any earlier calibration result
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata_o = st_q.rdata;
	assign conv_run_o = st_q.conv_run;
	assign pwr_down_o = st_q.pwr_down;
	assign off_cal_o = st_q.off_cal;
	assign gain_cal_o = st_q.gain_cal;
	assign pos_offset_dac_connect_o = st_q.dac_pos[BIT_DAC_CONN];
	assign pos_offset_dac_code_o = st_q.dac_pos[6:0];
	assign neg_offset_dac_connect_o = st_q.dac_neg[BIT_DAC_CONN];
	assign neg_offset_dac_code_o = st_q.dac_neg[6:0];
	// The core forms (pos - dac_pos) - (neg - dac_neg) when set
	assign differential_select_o = st_q.cap_setup[BIT_DIFF];
	assign cap_input_neg_connect_o = st_q.cap_setup[BIT_DIFF];
	assign excitation_out_first_en_o = st_q.exc_setup[BIT_EXC1_EN];
	assign excitation_out_first_inv_o = st_q.exc_setup[BIT_EXC1_INV];
	assign excitation_out_second_en_o = st_q.exc_setup[BIT_EXC2_EN];
	assign excitation_out_second_inv_o = st_q.exc_setup[BIT_EXC2_INV];

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence s_wr(logic [7:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence

	sequence s_offcal_done;
		cur_mode == MODE_OFFCAL && filt_valid_i && filt_is_cap_i;
	endsequence

	sequence s_single_done;
		cur_mode == MODE_SINGLE && filt_valid_i;
	endsequence

	mode_down_a: assert property (
		reg_wr_i && reg_addr_i == ADR_CFG &&
		reg_wdata_i[2:0] == MODE_PWRDN && !filt_valid_i
		|=> pwr_down_o && !conv_run_o && !off_cal_o)
		else $error("power-down mode not decoded");

	pos_dac_a: assert property (
		s_wr(ADR_DAC_POS) |=> pos_offset_dac_connect_o ==
		$past(reg_wdata_i[7]) && pos_offset_dac_code_o ==
		$past(reg_wdata_i[6:0]))
		else $error("positive DAC setting not applied");

	neg_dac_a: assert property (
		s_wr(ADR_DAC_NEG) |=> neg_offset_dac_connect_o ==
		$past(reg_wdata_i[7]) && neg_offset_dac_code_o ==
		$past(reg_wdata_i[6:0]))
		else $error("negative DAC setting not applied");

	off_cal_upd_a: assert property (
		s_offcal_done |=> ((st_q.off_coef == $past(cal_off) &&
		cur_mode == MODE_IDLE) and (reg_rd_i && reg_addr_i == ADR_CFG
		|=> reg_rdata_o[2:0] == MODE_IDLE)))
		else $error("offset calibration result not stored");

	single_idle_a: assert property (
		s_single_done |=> cur_mode == MODE_IDLE && !conv_run_o)
		else $error("single conversion did not return to idle");

	diff_sel_a: assert property (
		s_wr(ADR_CAP_SETUP) |=> cap_input_neg_connect_o ==
		$past(reg_wdata_i[BIT_DIFF]))
		else $error("negative input switch wrong");

	otp_load_a: assert property (
		$fell(st_q.otp_pend) && !$past(reg_wr_i) |->
		st_q.cgain == $past(otp_cap_gain_i) &&
		st_q.vgain == $past(otp_volt_gain_i))
		else $error("factory gain not loaded");

	reset_vals_a: assert property (
		st_q.otp_pend |-> st_q.off_coef == RST_OFF_COEF &&
		st_q.cfg == RST_CFG)
		else $error("reset values wrong");

	result_lat_a: assert property (
		filt_valid_i |=> result_valid_o &&
		result_is_cap_o == $past(filt_is_cap_i))
		else $error("corrected result missing");

	exc_indep_a: assert property (
		s_wr(ADR_EXC_SETUP) |=> excitation_out_first_en_o ==
		$past(reg_wdata_i[BIT_EXC1_EN]) && excitation_out_second_en_o ==
		$past(reg_wdata_i[BIT_EXC2_EN]))
		else $error("excitation enables wrong");
endmodule
`default_nettype wire

//--- testbench/ccm_host_model.sv
// Purpose: host controller model driving the byte register port
// Assumes: requests launch on falling edges, block samples on rising
// Notes: idle address and data show the inverse of the last value
////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module ccm_host_model
	import ccm_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
		d = reg_rdata_i;
		reg_addr_o = ~a;
	endtask

	// DACs and offset are shared, so a channel switch reloads all of them
	task automatic load_channel(input logic [7:0] dp, input logic [7:0] dn,
			input logic [15:0] off);
		wr(ADR_DAC_POS, dp);
		wr(ADR_DAC_NEG, dn);
		wr(ADR_OFF_HI, off[15:8]);
		wr(ADR_OFF_LO, off[7:0]);
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: filter results are injected directly on the filter port
// Notes: no analog core model; steering outputs are checked as levels
////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import ccm_pkg::*;
;
	localparam logic [15:0] OTP_CAP = 16'h8000;
	localparam logic [15:0] OTP_VOLT = 16'h4000;
	logic clk_i, resetn_i, reg_wr, reg_rd, filt_valid, filt_is_cap;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [15:0] otp_cap, otp_volt;
	logic [23:0] filt_data, result;
	logic conv_run, pwr_down, off_cal, gain_cal, pos_conn, neg_conn;
	logic neg_in_conn, diff_sel, e1en, e1inv, e2en, e2inv, res_valid, res_cap;
	logic [6:0] pos_code, neg_code;
	logic [15:0] dac_all;
	assign dac_all = {pos_conn, pos_code, neg_conn, neg_code};
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] def_adr [12] = '{ADR_CFG, ADR_DAC_POS, ADR_DAC_NEG,
		ADR_OFF_HI, ADR_OFF_LO, ADR_CGAIN_HI, ADR_CGAIN_LO, ADR_VGAIN_HI,
		ADR_VGAIN_LO, ADR_EXC_SETUP, ADR_CAP_SETUP, 8'h20};
	logic [7:0] def_val [12] = '{8'hA0, 8'h00, 8'h00, 8'h80, 8'h00,
		OTP_CAP[15:8], OTP_CAP[7:0], OTP_VOLT[15:8], OTP_VOLT[7:0], 8'h03,
		8'h00, 8'h00};
	logic [3:0] mode_exp [8] = '{4'h0, 4'h8, 4'h8, 4'h4, 4'h0, 4'h2, 4'h1,
		4'h0};

	ccm_host_model host_u (.clk_i(clk_i), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_rdata_i(reg_rdata));

	ccm_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.otp_cap_gain_i(otp_cap), .otp_volt_gain_i(otp_volt),
		.filt_data_i(filt_data), .filt_valid_i(filt_valid),
		.filt_is_cap_i(filt_is_cap), .conv_run_o(conv_run),
		.pwr_down_o(pwr_down), .off_cal_o(off_cal), .gain_cal_o(gain_cal),
		.pos_offset_dac_connect_o(pos_conn), .pos_offset_dac_code_o(pos_code),
		.neg_offset_dac_connect_o(neg_conn), .neg_offset_dac_code_o(neg_code),
		.cap_input_neg_connect_o(neg_in_conn),
		.differential_select_o(diff_sel),
		.excitation_out_first_en_o(e1en), .excitation_out_first_inv_o(e1inv),
		.excitation_out_second_en_o(e2en),
		.excitation_out_second_inv_o(e2inv), .result_o(result),
		.result_valid_o(res_valid), .result_is_cap_o(res_cap));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("wrong value at %0t: run timed out", $time);
			final_report();
		end
	end

	// Reference correction; offset step is 64 result codes, gain 0x8000 = 1
	function automatic logic [23:0] corr(input logic [23:0] d,
			input logic [15:0] off, input logic [15:0] g);
		longint t;
		t = longint'(d) - longint'(24'h80_0000);
		t = t - (longint'(off) - longint'(16'h8000)) * 64;
		t = ((t * longint'(g)) >>> 15) + longint'(24'h80_0000);
		if (t < 0) t = 0;
		if (t > longint'(24'hFF_FFFF)) t = longint'(24'hFF_FFFF);
		return t[23:0];
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
			input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(24'(d), 24'(e), $sformatf("register %h", a));
	endtask

	task automatic feed(input logic [23:0] d, input logic cap);
		@(negedge clk_i);
		filt_data = d;
		filt_is_cap = cap;
		filt_valid = 1'b1;
		@(negedge clk_i);
		filt_valid = 1'b0;
		filt_data = ~d;
		chk(24'({res_valid, res_cap}), 24'({1'b1, cap}), "result flags");
	endtask

	task automatic feed_chk(input logic [23:0] d, input logic cap,
			input logic [15:0] off, input logic [15:0] g);
		feed(d, cap);
		chk(result, corr(d, off, g), "corrected result");
	endtask

	task automatic do_reset;
		resetn_i = 1'b0;
		repeat (8) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (5) @(negedge clk_i);
	endtask

	task automatic check_defaults;
		for (int i = 0; i < 12; i++) begin
			rd_chk(def_adr[i], def_val[i]);
		end
		chk(24'({conv_run, pwr_down, off_cal, gain_cal}), 24'h00_0000,
			"idle outputs");
	endtask

	task final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		resetn_i = 1'b0;
		otp_cap = OTP_CAP;
		otp_volt = OTP_VOLT;
		filt_data = 24'h00_0000;
		filt_valid = 1'b0;
		filt_is_cap = 1'b0;
		do_reset();
		check_defaults();
		// Channel load, then capacitive and voltage correction
		host_u.load_channel(8'h85, 8'hFF, 16'h8001);
		chk(24'(dac_all), 24'h00_85FF, "dac");
		feed_chk(24'h80_0100, 1'b1, 16'h8001, OTP_CAP);
		host_u.wr(ADR_CGAIN_HI, 8'h40);
		feed_chk(24'h80_0100, 1'b1, 16'h8001, 16'h4000);
		feed_chk(24'h80_0100, 1'b0, 16'h8000, OTP_VOLT);
		host_u.wr(ADR_CGAIN_HI, 8'h80);
		host_u.load_channel(8'h7F, 8'h00, 16'h0000);
		chk(24'(dac_all), 24'h00_7F00, "dac");
		feed_chk(24'hF0_0000, 1'b1, 16'h0000, 16'h8000);
		// Input selection and excitation
		host_u.wr(ADR_CAP_SETUP, 8'h20);
		chk(24'({diff_sel, neg_in_conn}), 24'h00_0003, "diff");
		host_u.wr(ADR_CAP_SETUP, 8'h00);
		chk(24'({diff_sel, neg_in_conn}), 24'h00_0000, "single");
		host_u.wr(ADR_EXC_SETUP, 8'h28);
		chk(24'({e2en, e2inv, e1en, e1inv}), 24'h00_000A, "exc");
		host_u.wr(ADR_EXC_SETUP, 8'h14);
		chk(24'({e2en, e2inv, e1en, e1inv}), 24'h00_0005, "exc inv");
		host_u.wr(ADR_EXC_SETUP, 8'h08);
		chk(24'({e2en, e2inv, e1en, e1inv}), 24'h00_0002, "exc one");
		// Every mode code, including the two that do nothing
		for (int m = 0; m < 8; m++) begin
			host_u.wr(ADR_CFG, 8'hA0 | 8'(m));
			chk(24'({conv_run, pwr_down, off_cal, gain_cal}), 24'(mode_exp[m]),
				"mode");
		end
		rd_chk(ADR_CFG, 8'hA7);
		// Single conversion ends in idle
		host_u.wr(ADR_CFG, 8'hA2);
		feed(24'h80_0000, 1'b1);
		rd_chk(ADR_CFG, 8'hA0);
		chk(24'(conv_run), 24'h00_0000, "single done");
		// Offset calibration: a voltage result must not finish it
		host_u.wr(ADR_CFG, 8'hA5);
		feed(24'h80_1000, 1'b0);
		chk(24'(off_cal), 24'h00_0001, "cal held");
		feed(24'h80_1000, 1'b1);
		rd_chk(ADR_OFF_HI, 8'h80);
		rd_chk(ADR_OFF_LO, 8'h40);
		rd_chk(ADR_CFG, 8'hA0);
		host_u.wr(ADR_CFG, 8'hA1);
		feed(24'h80_1000, 1'b1);
		chk(result, 24'h80_0000, "midpoint");
		// Gain calibration at full scale gives unity
		host_u.wr(ADR_CFG, 8'hA0);
		host_u.load_channel(8'h00, 8'h00, 16'h8000);
		host_u.wr(ADR_CGAIN_HI, 8'h12);
		host_u.wr(ADR_CFG, 8'hA6);
		feed(24'hFF_FFFF, 1'b1);
		rd_chk(ADR_CGAIN_HI, 8'h80);
		rd_chk(ADR_CGAIN_LO, 8'h00);
		rd_chk(ADR_CFG, 8'hA0);
		// Second reset in mid-run discards user values
		host_u.wr(ADR_OFF_HI, 8'h12);
		host_u.wr(ADR_CGAIN_LO, 8'h55);
		host_u.wr(ADR_VGAIN_HI, 8'h77);
		host_u.wr(ADR_CFG, 8'hA1);
		do_reset();
		check_defaults();
		final_report();
	end
endmodule
`default_nettype wire
